/* logic/led_pwm_pkg.sv */
// shared constants and types for the six channel led pwm block
package led_pwm_pkg;

	// channel count and register bus geometry
	localparam int unsigned NUM_CH     = 6;
	localparam int unsigned ADDR_W     = 8;
	localparam int unsigned DATA_W     = 32;

	// byte offsets: one config word per channel, then a status word
	localparam logic [7:0]  CH_CFG_BASE = 8'h00;
	localparam logic [7:0]  CH_CFG_STEP = 8'h04;
	localparam logic [7:0]  STATUS_OFS  = 8'h18;

	// config word field positions
	localparam int unsigned EN_POS     = 0;
	localparam int unsigned RATE_LSB   = 1;
	localparam int unsigned DUTY_LSB   = 4;
	localparam int unsigned CFG_W      = 8;

	// reset values: channel off, slowest rate, shortest duty
	localparam logic [7:0]  CH_CFG_RST = 8'h00;

	// axi response codes
	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// timebase: clock rate and the period is cut into sixteen slots
	localparam longint unsigned CLK_HZ    = 64'd100_000_000;
	localparam longint unsigned SLOTS     = 64'd16;

	// pwm rates in millihertz, as printed in hertz times 1000
	localparam longint unsigned RATE0_MHZ = 64'd250;
	localparam longint unsigned RATE1_MHZ = 64'd500;
	localparam longint unsigned RATE2_MHZ = 64'd1000;
	localparam longint unsigned RATE3_MHZ = 64'd2000;
	localparam longint unsigned RATE4_MHZ = 64'd128000;
	localparam longint unsigned RATE5_MHZ = 64'd256000;

	// clock cycles per slot, rounded down so the rate is never slow
	localparam longint unsigned SLOT0_CYC = CLK_HZ * 1000 / (RATE0_MHZ * SLOTS);
	localparam longint unsigned SLOT1_CYC = CLK_HZ * 1000 / (RATE1_MHZ * SLOTS);
	localparam longint unsigned SLOT2_CYC = CLK_HZ * 1000 / (RATE2_MHZ * SLOTS);
	localparam longint unsigned SLOT3_CYC = CLK_HZ * 1000 / (RATE3_MHZ * SLOTS);
	localparam longint unsigned SLOT4_CYC = CLK_HZ * 1000 / (RATE4_MHZ * SLOTS);
	localparam longint unsigned SLOT5_CYC = CLK_HZ * 1000 / (RATE5_MHZ * SLOTS);

	// prescaler width, enough for the slowest slot
	localparam int unsigned PRE_W      = 25;

	// one channel's settings as software writes them
	typedef struct packed {
		logic [3:0] duty;   // on-time is (duty+1) sixteenths
		logic [2:0] rate;   // frequency select
		logic       en;     // channel drives its pin when set
	} chan_cfg_t;

	// bus handshake states, gray along idle -> answer
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_RESP = 2'b01
	} bus_state_t;

endpackage : led_pwm_pkg

/* logic/six_channel_led_pwm.sv */
// six independent low-rate pwm led channels behind an axi4-lite slave
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module six_channel_led_pwm #(
	// clock cycles per slot for each rate code; a bench may shrink them
	parameter int unsigned SLOT0 = int'(led_pwm_pkg::SLOT0_CYC),
	parameter int unsigned SLOT1 = int'(led_pwm_pkg::SLOT1_CYC),
	parameter int unsigned SLOT2 = int'(led_pwm_pkg::SLOT2_CYC),
	parameter int unsigned SLOT3 = int'(led_pwm_pkg::SLOT3_CYC),
	parameter int unsigned SLOT4 = int'(led_pwm_pkg::SLOT4_CYC),
	parameter int unsigned SLOT5 = int'(led_pwm_pkg::SLOT5_CYC)
) (
	input  wire logic                           clk,
	input  wire logic                           reset,
	// write address channel
	input  wire logic [led_pwm_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                           s_axi_awvalid,
	output logic                                s_axi_awready,
	// write data channel
	input  wire logic [led_pwm_pkg::DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]                     s_axi_wstrb,
	input  wire logic                           s_axi_wvalid,
	output logic                                s_axi_wready,
	// write response channel
	output logic [1:0]                          s_axi_bresp,
	output logic                                s_axi_bvalid,
	input  wire logic                           s_axi_bready,
	// read address channel
	input  wire logic [led_pwm_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                           s_axi_arvalid,
	output logic                                s_axi_arready,
	// read data channel
	output logic [led_pwm_pkg::DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]                          s_axi_rresp,
	output logic                                s_axi_rvalid,
	input  wire logic                           s_axi_rready,
	// led driver pins, one per channel
	output logic [led_pwm_pkg::NUM_CH-1:0]      pwm_led_out
);
	// constants, field layout and state codes of the block
	import led_pwm_pkg::*;

	// per-channel settings, written by software
	chan_cfg_t                  cfg_q [NUM_CH];
	// write side handshake state
	bus_state_t                 wr_state_q;
	// read side handshake state
	bus_state_t                 rd_state_q;
	// registered answers
	logic [1:0]                 bresp_q;
	logic [DATA_W-1:0]          rdata_q;
	logic [1:0]                 rresp_q;
	// pin levels, also readable in the status word
	logic [NUM_CH-1:0]          pwm_q;
	// a write is taken when both address and data are offered and we are idle
	logic                       wr_take;
	// a read is taken when the address is offered and we are idle
	logic                       rd_take;
	// decoded write target
	logic [NUM_CH-1:0]          wr_hit;
	// address names a writable channel
	logic                       wr_ok;

	// index that no channel uses, the answer for every other address
	localparam logic [2:0] NO_CHAN = 3'(NUM_CH);

	// channel index of an address, or NO_CHAN when it is no channel
	// only exact aligned matches count, so a stray byte address or an
	// address past the last channel can never alias onto a channel
	function automatic logic [2:0] chan_of(input logic [ADDR_W-1:0] a);
		logic [2:0] idx;
		idx = NO_CHAN;
		// compare against each channel's own config word
		for (int unsigned i = 0; i < NUM_CH; i++) begin
			if (a == CH_CFG_BASE + CH_CFG_STEP * 8'(i)) begin
				// a match names the channel
				idx = 3'(i);
			end
		end
		return idx;
	endfunction : chan_of

	// cycles in one slot for a rate code
	function automatic logic [PRE_W-1:0] slot_len(input logic [2:0] r);
		logic [PRE_W-1:0] n;
		// start from the fastest rate so n is always set
		n = PRE_W'(SLOT5);
		case (r)
			3'h0: n = PRE_W'(SLOT0);
			3'h1: n = PRE_W'(SLOT1);
			3'h2: n = PRE_W'(SLOT2);
			3'h3: n = PRE_W'(SLOT3);
			// blink rates above, dim rates below
			3'h4: n = PRE_W'(SLOT4);
			3'h5: n = PRE_W'(SLOT5);
			default: n = PRE_W'(SLOT5);
		endcase
		return n;
	endfunction : slot_len

	// register bus: write path
	// one write in flight; reads run alongside on their own state

	// both write channels are taken in one edge; holding ready low
	// until both are there avoids buffering a lone address or data
	assign wr_take       = s_axi_awvalid && s_axi_wvalid
	                       && (wr_state_q == BUS_IDLE);
	assign s_axi_awready = wr_take;
	assign s_axi_wready  = wr_take;

	// decode the write address once for all channels
	always_comb begin
		// defaults: no channel hit, answer slave error
		wr_hit = '0;
		wr_ok  = 1'b0;
		if (chan_of(s_axi_awaddr) != NO_CHAN) begin
			// one-hot select of the addressed channel
			wr_hit[chan_of(s_axi_awaddr)] = 1'b1;
			// a hit is the only way to an okay answer
			wr_ok = 1'b1;
		end
	end

	// write response state: idle until taken, answer until bready
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			// no answer pending out of reset
			wr_state_q <= BUS_IDLE;
			bresp_q    <= RESP_OKAY;
		end else begin
			case (wr_state_q)
				// wait for address and data together
				BUS_IDLE: begin
					if (wr_take) begin
						// both halves taken: answer next cycle
						wr_state_q <= BUS_RESP;
						// status word and holes answer slave error
						bresp_q    <= wr_ok ? RESP_OKAY : RESP_SLVERR;
					end
				end
				// hold the answer until the master takes it
				BUS_RESP: begin
					if (s_axi_bready) begin
						// answer taken, ready for the next write
						wr_state_q <= BUS_IDLE;
					end
				end
				default: begin
					// unused code: fall back to idle, never lock up
					wr_state_q <= BUS_IDLE;
				end
			endcase
		end
	end

	// answer flag comes straight from the state, so it never glitches
	assign s_axi_bvalid = (wr_state_q == BUS_RESP);
	assign s_axi_bresp  = bresp_q;

	// channel config words; only byte lane 0 carries fields
	generate
		for (genvar c = 0; c < NUM_CH; c++) begin : g_cfg
			// one process per channel keeps each write enable local
			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					// every channel starts off and parked
					cfg_q[c] <= chan_cfg_t'(CH_CFG_RST);
				end else if (wr_take && wr_hit[c] && s_axi_wstrb[0]) begin
					// upper data bits are dropped; the word has no more
					// fields, so upper lanes alone never change a channel
					cfg_q[c] <= chan_cfg_t'(s_axi_wdata[CFG_W-1:0]);
				end
			end
		end
	endgenerate

	// register bus: read path
	// reads never wait for writes; each side has its own state

	// one read in flight; the address is refused while answering
	assign rd_take       = s_axi_arvalid && (rd_state_q == BUS_IDLE);
	assign s_axi_arready = rd_take;

	// read answer state and data capture
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			// nothing to answer out of reset
			rd_state_q <= BUS_IDLE;
			rdata_q    <= '0;
			rresp_q    <= RESP_OKAY;
		end else begin
			case (rd_state_q)
				// capture data at the edge that takes the address
				BUS_IDLE: begin
					if (rd_take) begin
						// address taken: data stands from next cycle
						rd_state_q <= BUS_RESP;
						// okay unless the address is a hole
						rresp_q    <= RESP_OKAY;
						// clear first so unused bits read zero
						rdata_q    <= '0;
						if (chan_of(s_axi_araddr) != NO_CHAN) begin
							// config word, upper bits zero
							rdata_q[CFG_W-1:0] <= cfg_q[chan_of(s_axi_araddr)];
						end else if (s_axi_araddr == STATUS_OFS) begin
							// live pin levels, so software can see blinking
							rdata_q[NUM_CH-1:0] <= pwm_q;
						end else begin
							// unmapped or unaligned: error, data zero
							rresp_q <= RESP_SLVERR;
						end
					end
				end
				// hold data until the master takes it
				BUS_RESP: begin
					if (s_axi_rready) begin
						// data taken, accept the next address
						rd_state_q <= BUS_IDLE;
					end
				end
				default: begin
					// unused code: fall back to idle
					rd_state_q <= BUS_IDLE;
				end
			endcase
		end
	end

	// read answer leaves straight from registers
	assign s_axi_rvalid = (rd_state_q == BUS_RESP);
	assign s_axi_rdata  = rdata_q;
	assign s_axi_rresp  = rresp_q;

	// pwm channels
	// six identical channels; nothing is shared between them

	generate
		for (genvar c = 0; c < NUM_CH; c++) begin : g_pwm
			// each channel owns its prescaler and slot counter
			// cycles elapsed inside the current slot
			logic [PRE_W-1:0] pre_q;
			// slot number inside the period, 0..15
			logic [3:0]       slot_q;
			// last cycle of a slot
			logic             slot_end;

			// a shorter rate written mid-slot ends the slot at once
			// rather than letting the prescaler run to its wrap
			// limitation: a longer rate written mid-slot stretches it
			assign slot_end = (pre_q >= slot_len(cfg_q[c].rate) - PRE_W'(1));

			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					// period starts at slot 0 after reset
					pre_q  <= '0;
					slot_q <= '0;
				end else if (!cfg_q[c].en) begin
					// disabled: park so enabling starts a fresh period
					pre_q  <= '0;
					slot_q <= '0;
				end else if (slot_end) begin
					// next slot; 15 wraps to 0 for a new period
					pre_q  <= '0;
					slot_q <= slot_q + 4'h1;
				end else begin
					// still inside the slot
					pre_q  <= pre_q + PRE_W'(1);
				end
			end

			// pin level is registered so it never glitches
			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					// led dark during reset
					pwm_q[c] <= 1'b0;
				end else begin
					// duty 15 is never passed, so the pin stays on
					// gated by enable
					pwm_q[c] <= cfg_q[c].en && (slot_q <= cfg_q[c].duty);
				end
			end
		end
	endgenerate

	// pins leave straight from the channel flip-flops
	assign pwm_led_out = pwm_q;

endmodule : six_channel_led_pwm

`default_nettype wire

/* test/led_pwm_monitor.sv */
// checker for the led pwm bus handshakes
`timescale 1ns/1ns
`default_nettype none
module led_pwm_monitor (
	input wire logic	clk,
	input wire logic	reset,
	input wire logic	s_axi_awvalid,
	input wire logic	s_axi_awready,
	input wire logic	s_axi_wvalid,
	input wire logic	s_axi_wready,
	input wire logic [1:0]	s_axi_bresp,
	input wire logic	s_axi_bvalid,
	input wire logic	s_axi_bready,
	input wire logic	s_axi_arvalid,
	input wire logic	s_axi_arready,
	input wire logic [led_pwm_pkg::DATA_W-1:0] s_axi_rdata,
	input wire logic	s_axi_rvalid,
	input wire logic	s_axi_rready
);
	import led_pwm_pkg::*;
	// one clock domain, so one clocking and one disable
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	chk_write_answer: assert property (s_axi_awready |=> s_axi_bvalid)
		else $error("write not answered next cycle");
	chk_read_answer: assert property (s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered next cycle");
	chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
	chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
	chk_write_pair: assert property (s_axi_awready
		|-> s_axi_wready && s_axi_awvalid && s_axi_wvalid)
		else $error("write taken half");
	chk_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write taken while busy");
	chk_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	// fields are narrow, so the upper data bits never carry anything
	chk_upper_zero: assert property (s_axi_rvalid
		|-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits set");
endmodule : led_pwm_monitor
bind six_channel_led_pwm led_pwm_monitor i_led_pwm_monitor (.clk(clk),
	.reset(reset), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready));
`default_nettype wire

/* test/led_load_model.sv */
// six led loads that time each pin's high and low runs
`timescale 1ns/1ns
`default_nettype none
module led_load_model (
	input wire logic	clk,
	input wire logic	reset,
	input wire logic [led_pwm_pkg::NUM_CH-1:0] pins,
	output var int		hi_len [led_pwm_pkg::NUM_CH],
	output var int		lo_len [led_pwm_pkg::NUM_CH]
);
	import led_pwm_pkg::*;
	int			run [NUM_CH];	// cycles in current level
	logic [NUM_CH-1:0]	last_q;		// level seen last edge
	always @(posedge clk) begin
		last_q <= pins;
		for (int c = 0; c < NUM_CH; c++) begin
			if (reset) begin
				hi_len[c] <= 0;
				lo_len[c] <= 0;
				run[c] <= 0;
			end else if (pins[c] != last_q[c]) begin
				// a run only counts once it has ended
				if (last_q[c]) hi_len[c] <= run[c];
				else lo_len[c] <= run[c];
				run[c] <= 1;
			end else run[c] <= run[c] + 1;
		end
	end
endmodule : led_load_model
`default_nettype wire

/* test/tb_top.sv */
// self-checking bench for the six channel led pwm block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
	$display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); end end
module tb_top;
	import led_pwm_pkg::*;
	localparam int SL [6] = '{8, 6, 5, 4, 3, 2};	// short sim slots
	logic		clk = 1'b0;
	logic		reset = 1'b1;
	logic [7:0]	awaddr = 8'h0, araddr = 8'h0;
	logic [31:0]	wdata = 32'h0, rdata;
	logic		awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic		arvalid = 1'b0, rready = 1'b0;
	logic [3:0]	wstrb = 4'hf;
	logic		awready, wready, bvalid, arready, rvalid;
	logic [1:0]	bresp, rresp;
	logic [5:0]	pins;
	int		hi_len [NUM_CH], lo_len [NUM_CH];
	int		n_mismatch = 0, compares = 0;
	always #5 clk = ~clk;
	six_channel_led_pwm #(.SLOT0(SL[0]), .SLOT1(SL[1]), .SLOT2(SL[2]),
		.SLOT3(SL[3]), .SLOT4(SL[4]), .SLOT5(SL[5]))
		i_six_channel_led_pwm (.clk(clk),
		.reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .pwm_led_out(pins));
	led_load_model i_led_load_model (.clk(clk), .reset(reset), .pins(pins),
		.hi_len(hi_len), .lo_len(lo_len));
	// bready comes late so the slave must hold its answer
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do @(negedge clk); while (!awready);
		@(posedge clk);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(negedge clk); while (!bvalid);
		`CHK(bresp, er)
		@(posedge clk);
		bready <= 1'b1;
		@(posedge clk);
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		do @(negedge clk); while (!arready);
		@(posedge clk);
		arvalid <= 1'b0;
		do @(negedge clk); while (!rvalid);
		`CHK(rdata, ed)
		`CHK(rresp, er)
		@(posedge clk);
		rready <= 1'b1;
		@(posedge clk);
		rready <= 1'b0;
	endtask : rd
	task automatic results();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results
	// tests: register access, then pin timing per channel
	initial begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		for (int c = 0; c <= NUM_CH; c++) rd(8'(4 * c), 32'h0, RESP_OKAY);
		// each channel its own rate and duty; upper bits are ignored
		for (int c = 0; c < NUM_CH; c++)
			wr(8'(4 * c), {24'hffffff, 4'(3 * c), 3'(c), 1'b1}, RESP_OKAY);
		for (int c = 0; c < NUM_CH; c++)
			rd(8'(4 * c), {24'h0, 4'(3 * c), 3'(c), 1'b1}, RESP_OKAY);
		repeat (300) @(posedge clk);
		@(negedge clk);
		for (int c = 0; c < 5; c++) begin
			`CHK(hi_len[c], (3 * c + 1) * SL[c])
			`CHK(lo_len[c], (15 - 3 * c) * SL[c])
		end
		`CHK(pins[5], 1'b1)
		`CHK(hi_len[5], 0)
		// undefined rate codes run at the fastest rate
		for (int k = 6; k < 8; k++) begin
			wr(8'h00, {24'h0, 4'h1, 3'(k), 1'b1}, RESP_OKAY);
			repeat (200) @(posedge clk);
			@(negedge clk);
			`CHK(hi_len[0], 2 * SL[5])
			`CHK(lo_len[0], 14 * SL[5])
		end
		// refused places answer with an error and change nothing
		wr(8'h18, 32'h3f, RESP_SLVERR);
		wr(8'h20, 32'h1, RESP_SLVERR);
		rd(8'h1c, 32'h0, RESP_SLVERR);
		rd(8'h02, 32'h0, RESP_SLVERR);
		rd(8'h00, 32'h1f, RESP_OKAY);
		// a write without byte lane 0 is answered but changes nothing
		wstrb <= 4'he;
		wr(8'h04, 32'h0, RESP_OKAY);
		wstrb <= 4'hf;
		rd(8'h04, 32'h33, RESP_OKAY);
		for (int c = 0; c < NUM_CH; c++) wr(8'(4 * c), 32'h0, RESP_OKAY);
		repeat (20) @(posedge clk);
		@(negedge clk);
		`CHK(pins, 6'h0)
		rd(8'h18, 32'h0, RESP_OKAY);
		results();
	end
	// watchdog, far beyond the fewer than a thousand cycles the tests need
	initial begin
		#200000;
		n_mismatch++;
		results();
	end
endmodule : tb_top
`default_nettype wire
